// >>> hdl/osp_parser.sv
// Purpose: Line parser for a serial-to-vehicle diagnostic interpreter
// Assumes: Host bytes arrive from a UART on the same clock; vehicle link is
//          a byte stream with message framing; NVM and ADC are outside
// Notes:   One line is handled at a time; the host is held off while busy
`timescale 1ns/1ps
module osp_parser #(
  parameter int unsigned STEP_CYC = osp_pkg::TO_STEP_CYC, // Cycles per step
  parameter logic [23:0] HDR = osp_pkg::HDR_DEF, // Request header bytes
  parameter logic [7:0] RX_ADDR = osp_pkg::RX_ADDR_DEF // Accepted reply address
) (
  input wire logic i_clk, // System clock, 250 MHz
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic i_rx_valid, // Host byte valid
  input wire logic [7:0] i_rx_data, // Host byte
  output logic o_rx_ready, // Parser takes host bytes
  output logic o_tx_valid, // Reply byte valid
  output logic [7:0] o_tx_data, // Reply byte
  input wire logic i_tx_ready, // Host link takes reply byte
  output logic o_veh_valid, // Vehicle byte valid
  output osp_pkg::osp_byte_t o_veh, // Vehicle byte and end mark
  input wire logic i_veh_ready, // Vehicle link takes byte
  input wire logic i_vrx_valid, // Received vehicle byte valid
  input wire osp_pkg::osp_vrx_t i_vrx, // Received vehicle byte and framing
  output logic o_vrx_ready, // Parser takes vehicle byte
  input wire logic i_nvm_id_present, // Identifier already in NVM
  input wire logic [95:0] i_nvm_id, // Stored identifier, first char low
  output logic o_nvm_id_wr, // Write identifier to NVM, pulse
  output logic [95:0] o_nvm_id, // Identifier to write
  input wire logic [15:0] i_volt_bcd, // Voltage as four BCD digits, 0.01 V
  output logic o_cal_wr, // Calibrate to reference, pulse
  output logic o_cal_factory, // Restore factory constants, pulse
  output logic [15:0] o_cal_bcd // Reference voltage, four BCD digits
);
  typedef enum logic [6:0] {
    S_LINE = 7'h01, S_EVAL = 7'h02, S_VSEND = 7'h04, S_VWAIT = 7'h08,
    S_FWD = 7'h10, S_REPLY = 7'h20, S_PROMPT = 7'h40
  } osp_state_t;

  // Refuse a buffer too short to hold an identifier store line
  if (osp_pkg::LINE_MAX < 4 + osp_pkg::ID_LEN) begin : g_bad_line
    $error("line buffer too short");
  end

  osp_state_t st_q; // Parser state
  logic [7:0] buf_q [osp_pkg::LINE_MAX]; // Line characters, spaces removed
  logic [4:0] len_q; // Stored character count
  logic ovf_q; // Line ran past the buffer
  logic loaded_q; // NVM identifier captured after reset
  logic id_set_q; // Identifier is committed
  logic [2:0] kind_q; // Reply being sent
  logic [3:0] idx_q; // Character or byte index
  logic [2:0] nb_q; // Request payload bytes
  logic [7:0] csum_q; // Running checksum
  logic [7:0] to_q; // Timeout in steps
  logic [9:0] dv_q; // Rounded voltage in 0.1 V
  logic match_q; // Current vehicle message matches
  logic got_q; // Any matching message seen
  logic [7:0] fb_q; // Byte being forwarded
  logic fl_q; // Forwarded byte ends a message
  logic tstart_q; // Timer restart pulse
  logic expired; // Timeout ran out

  // Character helpers
  function automatic logic is_hex(input logic [7:0] c);
    return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
  endfunction
  function automatic logic [3:0] hex_val(input logic [7:0] c);
    return (c <= 8'h39) ? c[3:0] : 4'(c[3:0] + 4'h9);
  endfunction
  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    return (n < 4'ha) ? {4'h3, n} : {4'h4, 4'(n - 4'h9)};
  endfunction

  // Reply text by kind and position
  function automatic logic [7:0] rep_chr(input logic [2:0] k, input logic [3:0] i,
                                         input logic [95:0] id, input logic [9:0] dv);
    logic [7:0] c;
    c = osp_pkg::CH_CR;
    case (k)
      osp_pkg::RP_QM: if (i == 4'h0) c = osp_pkg::CH_QM;
      osp_pkg::RP_OK: if (i < 4'h2) c = (i == 4'h0) ? 8'h4f : 8'h4b;
      osp_pkg::RP_ID: if (i < 4'hc) c = id[8*i +: 8];
      osp_pkg::RP_VOLT: begin
        case (i)
          4'h0: c = osp_pkg::CH_0 + 8'(dv / 10'd100);
          4'h1: c = osp_pkg::CH_0 + 8'((dv / 10'd10) % 10'd10);
          4'h2: c = 8'h2e;
          4'h3: c = osp_pkg::CH_0 + 8'(dv % 10'd10);
          4'h4: c = 8'h56;
          default: c = osp_pkg::CH_CR;
        endcase
      end
      osp_pkg::RP_NODATA: begin
        case (i)
          4'h0: c = 8'h4e;
          4'h1: c = 8'h4f;
          4'h2: c = osp_pkg::CH_SP;
          4'h3: c = 8'h44;
          4'h4: c = 8'h41;
          4'h5: c = 8'h54;
          4'h6: c = 8'h41;
          default: c = osp_pkg::CH_CR;
        endcase
      end
      default: c = osp_pkg::CH_CR;
    endcase
    return c;
  endfunction

  // Incoming host byte, folded to upper case
  wire rx_take = i_rx_valid && o_rx_ready;
  wire rx_lower = (i_rx_data >= 8'h61) && (i_rx_data <= 8'h7a);
  wire [7:0] rx_up = rx_lower ? (i_rx_data & 8'hdf) : i_rx_data;
  wire rx_skip = (i_rx_data == osp_pkg::CH_SP) || (i_rx_data == osp_pkg::CH_LF);

  // Per-entry checks over the buffered line
  logic [osp_pkg::LINE_MAX-1:0] hex_ok; // Entry is hex or past the end
  logic [osp_pkg::ID_LEN-1:0] id_ok; // Identifier character in range
  logic [3:0] dig_ok; // Calibration digit is decimal
  genvar g;
  generate
    for (g = 0; g < osp_pkg::LINE_MAX; g++) begin : g_chk
      assign hex_ok[g] = (5'(g) >= len_q) || is_hex(buf_q[g]);
      if (g < osp_pkg::ID_LEN) begin : g_id
        assign id_ok[g] = (buf_q[g+4] >= osp_pkg::ID_LO) && (buf_q[g+4] <= osp_pkg::ID_HI);
      end
      if (g < 4) begin : g_dig
        assign dig_ok[g] = (buf_q[g+4] >= 8'h30) && (buf_q[g+4] <= 8'h39);
      end
    end
  endgenerate

  // Line classification
  wire is_at = (len_q >= 5'd2) && (buf_q[0] == osp_pkg::CH_A) && (buf_q[1] == osp_pkg::CH_T);
  wire [15:0] cmd = {buf_q[2], buf_q[3]};
  wire req_ok = (&hex_ok) && !len_q[0] && (len_q <= 5'(2 * osp_pkg::REQ_MAX));
  wire id_good = (len_q == 5'(4 + osp_pkg::ID_LEN)) && (&id_ok) && !id_set_q;
  wire [15:0] cal_arg = {buf_q[4][3:0], buf_q[5][3:0], buf_q[6][3:0], buf_q[7][3:0]};
  wire [7:0] st_arg = {hex_val(buf_q[4]), hex_val(buf_q[5])};
  wire [95:0] id_line;
  generate
    for (g = 0; g < osp_pkg::ID_LEN; g++) begin : g_idl
      assign id_line[8*g +: 8] = buf_q[g+4];
    end
  endgenerate

  // Voltage rounded half up from 0.01 V to 0.1 V
  wire [9:0] v_tenths = 10'(i_volt_bcd[15:12] * 100 + i_volt_bcd[11:8] * 10 + i_volt_bcd[7:4]);
  wire [9:0] v_round = 10'(v_tenths + ((i_volt_bcd[3:0] >= 4'h5) ? 10'd1 : 10'd0));

  // Outgoing vehicle byte: header, payload, then checksum
  wire [3:0] pay_i = 4'(idx_q - 4'(osp_pkg::HDR_LEN));
  wire [7:0] pay_b = {hex_val(buf_q[{pay_i[2:0], 1'b0}]),
                      hex_val(buf_q[{pay_i[2:0], 1'b1}])};
  wire [3:0] sum_i = 4'(osp_pkg::HDR_LEN) + {1'b0, nb_q};
  wire [7:0] hdr_b = HDR[8*(2 - idx_q[1:0]) +: 8];
  wire [7:0] veh_b = (idx_q < 4'(osp_pkg::HDR_LEN)) ? hdr_b :
                     (idx_q < sum_i) ? pay_b : csum_q;
  wire veh_free = !o_veh_valid || i_veh_ready;
  wire tx_free = !o_tx_valid || i_tx_ready;
  wire [3:0] rep_len = (kind_q == osp_pkg::RP_OK) ? osp_pkg::LEN_OK :
                       (kind_q == osp_pkg::RP_ID) ? osp_pkg::LEN_ID :
                       (kind_q == osp_pkg::RP_VOLT) ? osp_pkg::LEN_VOLT :
                       (kind_q == osp_pkg::RP_NODATA) ? osp_pkg::LEN_NODATA : osp_pkg::LEN_QM;
  wire vrx_take = i_vrx_valid && o_vrx_ready;
  wire vrx_fwd = i_vrx.first ? (i_vrx.data == RX_ADDR) : match_q;

  osp_resp_timer #(.STEP_CYC(STEP_CYC)) u_timer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(tstart_q),
    .i_steps(to_q),
    .o_expired(expired)
  );

  // Line buffer: characters stored while gathering a line
  always_ff @(posedge i_clk) begin
    if (st_q == S_LINE && rx_take && !rx_skip && i_rx_data != osp_pkg::CH_CR &&
        len_q < 5'(osp_pkg::LINE_MAX)) begin
      buf_q[len_q[3:0]] <= rx_up;
    end
  end

  // Main sequencer
  always_ff @(posedge i_clk) begin
    o_nvm_id_wr <= 1'b0;
    o_cal_wr <= 1'b0;
    o_cal_factory <= 1'b0;
    tstart_q <= 1'b0;
    if (i_tx_ready) o_tx_valid <= 1'b0;
    if (i_veh_ready) o_veh_valid <= 1'b0;
    if (i_rst) begin
      st_q <= S_PROMPT; // Announce readiness after reset
      len_q <= 5'd0;
      ovf_q <= 1'b0;
      loaded_q <= 1'b0;
      id_set_q <= 1'b0;
      o_nvm_id <= 96'h0;
      kind_q <= osp_pkg::RP_QM;
      idx_q <= 4'h0;
      nb_q <= 3'h0;
      csum_q <= 8'h00;
      to_q <= osp_pkg::TO_DEF;
      dv_q <= 10'd0;
      match_q <= 1'b0;
      got_q <= 1'b0;
      fb_q <= 8'h00;
      fl_q <= 1'b0;
      o_rx_ready <= 1'b0;
      o_tx_valid <= 1'b0;
      o_tx_data <= 8'h00;
      o_veh_valid <= 1'b0;
      o_veh <= '0;
      o_vrx_ready <= 1'b0;
      o_cal_bcd <= 16'h0000;
    end else begin
      // Identifier state is taken from NVM once after reset
      if (!loaded_q) begin
        loaded_q <= 1'b1;
        id_set_q <= i_nvm_id_present;
        o_nvm_id <= i_nvm_id;
      end
      case (st_q)
        S_LINE: begin
          if (rx_take) begin
            if (i_rx_data == osp_pkg::CH_CR) begin
              st_q <= S_EVAL;
              o_rx_ready <= 1'b0;
            end else if (!rx_skip) begin
              if (len_q == 5'(osp_pkg::LINE_MAX)) ovf_q <= 1'b1;
              else len_q <= len_q + 5'd1;
            end
          end
        end
        S_EVAL: begin
          idx_q <= 4'h0;
          st_q <= S_REPLY;
          kind_q <= osp_pkg::RP_QM;
          if (ovf_q) begin
            st_q <= S_REPLY;
          end else if (len_q == 5'd0) begin
            st_q <= S_PROMPT;
          end else if (!is_at) begin
            if (req_ok) begin
              st_q <= S_VSEND;
              nb_q <= len_q[3:1];
              csum_q <= 8'h00;
            end
          end else if (cmd == osp_pkg::CMD_ID_STORE) begin
            if (id_good && loaded_q) begin
              id_set_q <= 1'b1;
              o_nvm_id <= id_line;
              o_nvm_id_wr <= 1'b1;
              kind_q <= osp_pkg::RP_OK;
            end
          end else if (cmd == osp_pkg::CMD_ID_SHOW && len_q == 5'd4) begin
            if (id_set_q) kind_q <= osp_pkg::RP_ID;
          end else if (cmd == osp_pkg::CMD_CV && len_q == 5'd8 && (&dig_ok)) begin
            o_cal_bcd <= cal_arg;
            o_cal_factory <= (cal_arg == 16'h0000);
            o_cal_wr <= (cal_arg != 16'h0000);
            kind_q <= osp_pkg::RP_OK;
          end else if (cmd == osp_pkg::CMD_RV && len_q == 5'd4) begin
            dv_q <= (v_round > 10'd999) ? 10'd999 : v_round;
            kind_q <= osp_pkg::RP_VOLT;
          end else if (cmd == osp_pkg::CMD_ST && len_q == 5'd6 && (&hex_ok[5:4])) begin
            to_q <= (st_arg == 8'h00) ? osp_pkg::TO_DEF : st_arg;
            kind_q <= osp_pkg::RP_OK;
          end
        end
        S_VSEND: begin
          if (veh_free) begin
            o_veh_valid <= 1'b1;
            o_veh.data <= veh_b;
            o_veh.last <= (idx_q == sum_i);
            csum_q <= csum_q + veh_b;
            idx_q <= idx_q + 4'h1;
            if (idx_q == sum_i) begin
              st_q <= S_VWAIT; // Timer starts once the checksum is out
              tstart_q <= 1'b1;
              got_q <= 1'b0;
              match_q <= 1'b0;
              o_vrx_ready <= 1'b1;
            end
          end
        end
        S_VWAIT: begin
          // An arriving byte wins over an expiry in the same cycle
          if (vrx_take) begin
            if (i_vrx.first) match_q <= vrx_fwd;
            if (vrx_fwd) begin
              got_q <= 1'b1;
              tstart_q <= 1'b1;
              fb_q <= i_vrx.data;
              fl_q <= i_vrx.last;
              idx_q <= 4'h0;
              st_q <= S_FWD;
              o_vrx_ready <= 1'b0;
            end
          end else if (expired && !tstart_q) begin
            o_vrx_ready <= 1'b0;
            idx_q <= 4'h0;
            kind_q <= osp_pkg::RP_NODATA;
            st_q <= got_q ? S_PROMPT : S_REPLY;
          end
        end
        S_FWD: begin
          // Each byte goes out as two hex digits and a separator
          if (tx_free) begin
            o_tx_valid <= 1'b1;
            idx_q <= idx_q + 4'h1;
            o_tx_data <= (idx_q == 4'h0) ? hex_chr(fb_q[7:4]) :
                         (idx_q == 4'h1) ? hex_chr(fb_q[3:0]) :
                         fl_q ? osp_pkg::CH_CR : osp_pkg::CH_SP;
            if (idx_q == 4'h2) begin
              st_q <= S_VWAIT;
              o_vrx_ready <= 1'b1;
            end
          end
        end
        S_REPLY: begin
          if (tx_free) begin
            o_tx_valid <= 1'b1;
            o_tx_data <= rep_chr(kind_q, idx_q, o_nvm_id, dv_q);
            idx_q <= idx_q + 4'h1;
            if (idx_q == rep_len - 4'h1) st_q <= S_PROMPT;
          end
        end
        S_PROMPT: begin
          if (tx_free) begin
            o_tx_valid <= 1'b1;
            o_tx_data <= osp_pkg::CH_PROMPT;
            len_q <= 5'd0;
            ovf_q <= 1'b0;
            st_q <= S_LINE;
            o_rx_ready <= 1'b1;
          end
        end
        default: st_q <= S_PROMPT;
      endcase
    end
  end
endmodule // osp_parser

// >>> hdl/osp_pkg.sv
// Purpose: Shared constants and carrier types for the serial command parser
// Assumes: 250 MHz system clock, ASCII host stream, byte-wide vehicle link
// Notes:   All counts derive from printed figures; header and address are defaults
package osp_pkg;
  // Clock rate and response timeout scaling
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned TO_STEP_US = 4000; // One timeout step is 4 ms
  localparam int unsigned TO_STEP_CYC = TO_STEP_US * CLK_MHZ;
  localparam logic [7:0] TO_DEF = 8'h20; // Default of 32 steps
  // Line and message limits
  localparam int unsigned LINE_MAX = 16; // Stored characters per line
  localparam int unsigned ID_LEN = 12; // Identifier characters
  localparam int unsigned REQ_MAX = 7; // Request payload bytes
  localparam int unsigned HDR_LEN = 3; // Header bytes ahead of payload
  localparam logic [7:0] ID_LO = 8'h21; // Lowest identifier character
  localparam logic [7:0] ID_HI = 8'h5f; // Highest identifier character
  // Characters
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_PROMPT = 8'h3e;
  localparam logic [7:0] CH_QM = 8'h3f;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_T = 8'h54;
  localparam logic [7:0] CH_0 = 8'h30;
  // Two-character command codes after the leading letters
  localparam logic [15:0] CMD_ID_STORE = 16'h4033; // store_identifier_cmd
  localparam logic [15:0] CMD_ID_SHOW = 16'h4032; // show_identifier_cmd
  localparam logic [15:0] CMD_CV = 16'h4356; // calibrate_voltage_cmd
  localparam logic [15:0] CMD_RV = 16'h5256; // read_voltage_cmd
  localparam logic [15:0] CMD_ST = 16'h5354; // set_response_timeout_cmd
  // Reply kinds and their lengths including the closing carriage return
  localparam logic [2:0] RP_QM = 3'h0;
  localparam logic [2:0] RP_OK = 3'h1;
  localparam logic [2:0] RP_ID = 3'h2;
  localparam logic [2:0] RP_VOLT = 3'h3;
  localparam logic [2:0] RP_NODATA = 3'h4;
  localparam logic [3:0] LEN_QM = 4'h2;
  localparam logic [3:0] LEN_OK = 4'h3;
  localparam logic [3:0] LEN_ID = 4'hd;
  localparam logic [3:0] LEN_VOLT = 4'h6;
  localparam logic [3:0] LEN_NODATA = 4'h8;
  // Default request header and receive address
  localparam logic [23:0] HDR_DEF = 24'h686af1;
  localparam logic [7:0] RX_ADDR_DEF = 8'hf1;

  // Byte toward the vehicle, last marks the checksum byte
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } osp_byte_t;

  // Byte from the vehicle with message framing
  typedef struct packed {
    logic [7:0] data;
    logic first;
    logic last;
  } osp_vrx_t;
endpackage

// >>> hdl/osp_resp_timer.sv
// Purpose: Response timeout in 4 ms steps for reply collection
// Assumes: i_start restarts the whole interval; i_steps is never zero
// Notes:   Expired is a level so a pulse cannot be missed while busy
`timescale 1ns/1ps
module osp_resp_timer #(
  parameter int unsigned STEP_CYC = osp_pkg::TO_STEP_CYC
) (
  input wire logic i_clk, // System clock
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic i_start, // Restart interval, one-cycle pulse
  input wire logic [7:0] i_steps, // Interval in steps
  output logic o_expired // High once the interval has run out
);
  localparam int unsigned PW = (STEP_CYC > 1) ? $clog2(STEP_CYC) : 1;

  // Refuse a step length that the prescaler cannot count
  if (STEP_CYC < 1) begin : g_bad_step
    $error("step count must be at least one");
  end

  logic [PW-1:0] pre_q; // Step prescaler
  logic [7:0] left_q; // Steps remaining
  logic run_q; // Interval in progress
  logic tick; // One-cycle step enable

  assign tick = run_q && (pre_q == PW'(STEP_CYC - 1));

  // Prescaler: one enable pulse per 4 ms step
  always_ff @(posedge i_clk) begin
    if (i_rst || i_start || tick) begin
      pre_q <= '0;
    end else if (run_q) begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // Step countdown; a restart always wins over an expiry in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      left_q <= 8'h00;
      run_q <= 1'b0;
      o_expired <= 1'b0;
    end else if (i_start) begin
      left_q <= i_steps;
      run_q <= 1'b1;
      o_expired <= 1'b0;
    end else if (tick) begin
      left_q <= left_q - 8'h01;
      if (left_q == 8'h01) begin
        run_q <= 1'b0;
        o_expired <= 1'b1;
      end
    end
  end
endmodule // osp_resp_timer

// >>> test/obd_serial_command_parser_tb.sv
// Purpose: Self-checking bench for the serial command parser
// Assumes: Step shortened to 10 cycles so timeouts stay short
// Notes:   Vehicle link ready stalls every other cycle throughout
`timescale 1ns/1ps
module obd_serial_command_parser_tb;
  logic i_clk = 1'b0, i_rst = 1'b1, i_veh_ready = 1'b0, i_vrx_valid = 1'b0;
  logic i_nvm_id_present = 1'b0, i_rx_valid, i_tx_ready;
  logic o_rx_ready, o_tx_valid, o_veh_valid, o_vrx_ready, o_nvm_id_wr, o_cal_wr, o_cal_factory;
  logic [7:0] i_rx_data, o_tx_data;
  logic [15:0] o_cal_bcd, i_volt_bcd = 16'h1247;
  logic [95:0] o_nvm_id, i_nvm_id = 96'h0;
  osp_pkg::osp_byte_t o_veh;
  osp_pkg::osp_vrx_t i_vrx = '0;
  int failures = 0, n_checks = 0, n_wr = 0, n_cal = 0, n_fac = 0;
  logic [8:0] vq[$]; // Bytes taken by the vehicle link
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] %0t mismatch, expected %0h", $time, b); end end
  always #2 i_clk = ~i_clk;
  always @(negedge i_clk) i_veh_ready <= ~i_veh_ready;
  // Record vehicle bytes and count pulses
  always @(posedge i_clk) begin
    if (o_veh_valid && i_veh_ready) vq.push_back(o_veh);
    n_wr += o_nvm_id_wr;
    n_cal += o_cal_wr;
    n_fac += o_cal_factory;
  end
  osp_parser #(.STEP_CYC(10)) i_dut (.i_clk, .i_rst, .i_rx_valid, .i_rx_data, .o_rx_ready,
    .o_tx_valid, .o_tx_data, .i_tx_ready, .o_veh_valid, .o_veh, .i_veh_ready, .i_vrx_valid,
    .i_vrx, .o_vrx_ready, .i_nvm_id_present, .i_nvm_id, .o_nvm_id_wr, .o_nvm_id, .i_volt_bcd,
    .o_cal_wr, .o_cal_factory, .o_cal_bcd);
  osp_host_model i_host (.i_clk(i_clk), .o_valid(i_rx_valid), .o_data(i_rx_data),
    .i_ready(o_rx_ready), .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data),
    .o_tx_ready(i_tx_ready));
  // One command line and its whole reply
  task automatic line(input string s, input string r);
    i_host.send(s);
    i_host.wait_prompt();
    `CHK(i_host.got(r), 1'b1)
  endtask
  // One three-byte vehicle message, first byte is the address
  task automatic vmsg(input logic [23:0] m);
    for (int i = 2; i >= 0; i--) begin
      @(negedge i_clk);
      i_vrx_valid = 1'b1;
      i_vrx = {m[i*8+:8], i == 2, i == 0};
      while (!o_vrx_ready) @(negedge i_clk);
      @(posedge i_clk);
    end
    @(negedge i_clk);
    i_vrx_valid = 1'b0;
    i_vrx.data = ~i_vrx.data;
  endtask
  // Silent vehicle: count cycles to the reply, expect no-data text
  task automatic t_nodata(input string s, input int lo, input int hi);
    int n = 0;
    i_host.send(s);
    while (!o_tx_valid && n < 3000) begin
      @(negedge i_clk);
      n++;
    end
    `CHK(n >= lo && n <= hi, 1'b1)
    i_host.wait_prompt();
    `CHK(i_host.got("NO DATA\015>"), 1'b1)
  endtask
  task automatic t_volt();
    line("at r V\015", "12.5V\015>");
    i_volt_bcd = 16'h0995;
    line("A t R v\015", "10.0V\015>");
    line("ATCV1247\015", "OK\015>");
    `CHK(o_cal_bcd, 16'h1247)
    line("atcv 0000\015", "OK\015>");
    `CHK(n_cal, 1)
    `CHK(n_fac, 1)
    $display("test volt done");
  endtask
  task automatic t_id();
    line("AT@2\015", "?\015>");
    line("AT@3ABC\015", "?\015>");
    line("AT@3ABCDEFGHIJ~L\015", "?\015>");
    line("AT@3ABCDEFGHIJKL\015", "OK\015>");
    `CHK(n_wr, 1)
    `CHK(o_nvm_id, "LKJIHGFEDCBA")
    line("at@2\015", "ABCDEFGHIJKL\015>");
    line("AT@3ZZZZZZZZZZZZ\015", "?\015>");
    line("AT@2\015", "ABCDEFGHIJKL\015>");
    `CHK(n_wr, 1)
    $display("test id done");
  endtask
  task automatic t_req();
    logic [8:0] ex[5] = '{9'h0d0, 9'h0d4, 9'h1e2, 9'h14c, 9'h0d3};
    vq.delete();
    i_host.slow = 1'b1;
    i_host.send(" a6\015");
    repeat (40) @(negedge i_clk);
    for (int i = 0; i < 5; i++) `CHK(vq[i], ex[i])
    vmsg(24'h104100);
    vmsg(24'hf14100);
    repeat (300) @(negedge i_clk);
    vmsg(24'hf14101);
    i_host.wait_prompt();
    `CHK(i_host.got("F1 41 00\015F1 41 01\015>"), 1'b1)
    i_host.slow = 1'b0;
    $display("test request done");
  endtask
  task automatic t_bad();
    vq.delete();
    line("0G\015", "?\015>");
    line("012\015", "?\015>");
    line("0102030405060708\015", "?\015>");
    line("ATXY\015", "?\015>");
    `CHK(vq.size(), 0)
    t_nodata("0100\015", 322, 350);
    line("ATST02\015", "OK\015>");
    t_nodata("01 00\015", 20, 45);
    line("ATST00\015", "OK\015>");
    vq.delete();
    t_nodata("01020304050607\015", 322, 370);
    `CHK(vq.size(), 11)
    $display("test errors done");
  endtask
  task automatic t_stored();
    @(negedge i_clk);
    i_rst = 1'b1;
    i_nvm_id_present = 1'b1;
    i_nvm_id = "MLKJIHGFEDCB";
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    i_host.wait_prompt();
    `CHK(i_host.got(">"), 1'b1)
    line("AT@2\015", "BCDEFGHIJKLM\015>");
    line("AT@3ABCDEFGHIJKL\015", "?\015>");
    `CHK(n_wr, 1)
    $display("test stored done");
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    i_host.wait_prompt();
    `CHK(i_host.got(">"), 1'b1)
    t_volt();
    t_id();
    t_req();
    t_bad();
    t_stored();
    finish_test();
  end
  // Watchdog well beyond the expected run of some 2000 cycles
  initial begin
    #200000;
    failures++;
    finish_test();
  end
endmodule // obd_serial_command_parser_tb

// >>> test/osp_host_model.sv
// Purpose: Behavioural serial terminal facing the parser
// Assumes: Bytes offered at the falling edge, taken on a rising edge
// Notes:   Released data line shows the inverse of the last byte
`timescale 1ns/1ps
module osp_host_model (
  input wire logic i_clk, // System clock
  output logic o_valid, // Host byte valid
  output logic [7:0] o_data, // Host byte
  input wire logic i_ready, // Parser takes byte
  input wire logic i_tx_valid, // Reply byte valid
  input wire logic [7:0] i_tx_data, // Reply byte
  output logic o_tx_ready // Terminal takes reply byte
);
  logic [7:0] rsp[$]; // Reply bytes gathered so far
  logic slow = 1'b0; // Stall the reply path every other cycle
  initial begin
    o_valid = 1'b0;
    o_data = 8'h00;
    o_tx_ready = 1'b1;
  end
  // Reply ready toggles when slow, to exercise the hold
  always @(negedge i_clk) o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
  // Gather every reply byte handed over
  always @(posedge i_clk) if (i_tx_valid && o_tx_ready) rsp.push_back(i_tx_data);
  // Send a line, holding each byte until the parser takes it
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge i_clk);
      o_valid = 1'b1;
      o_data = s[i];
      while (!i_ready) @(negedge i_clk);
      @(posedge i_clk);
    end
    @(negedge i_clk);
    o_valid = 1'b0;
    o_data = ~o_data;
  endtask
  // Bounded wait for the ready character
  task automatic wait_prompt();
    repeat (3000) begin
      @(negedge i_clk);
      if (rsp.size() > 0 && rsp[$] == 8'h3e) break;
    end
  endtask
  // Compare gathered reply with a text, then forget it
  function automatic bit got(input string r);
    bit ok = (rsp.size() == r.len());
    foreach (rsp[i]) if (ok && rsp[i] !== r[i]) ok = 1'b0;
    rsp.delete();
    return ok;
  endfunction
endmodule // osp_host_model

// >>> test/osp_parser_checker.sv
// Purpose: Port-level timing checks for the serial command parser
// Assumes: Single clock, synchronous active-high reset
// Notes:   Bound to every parser instance; watches its inputs and outputs
`timescale 1ns/1ps
module osp_parser_checker #(
  parameter logic [23:0] HDR = osp_pkg::HDR_DEF // Request header bytes
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic o_rx_ready,
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_data,
  input wire logic i_tx_ready,
  input wire logic o_veh_valid,
  input wire osp_pkg::osp_byte_t o_veh,
  input wire logic i_veh_ready,
  input wire logic i_vrx_valid,
  input wire osp_pkg::osp_vrx_t i_vrx,
  input wire logic o_vrx_ready,
  input wire logic o_nvm_id_wr,
  input wire logic o_cal_wr,
  input wire logic o_cal_factory
);
  logic wrote_q; // An identifier write has been seen since reset
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Remember the first write so a second one can be caught
  always_ff @(posedge i_clk) begin
    if (i_rst) wrote_q <= 1'b0;
    else if (o_nvm_id_wr) wrote_q <= 1'b1;
  end
  AST_PROMPT_AT_START: assert property ($fell(i_rst) |-> ##[1:2]
    (o_tx_valid && o_tx_data == osp_pkg::CH_PROMPT)) else $error("no prompt after reset");
  AST_REOPEN_WITH_PROMPT: assert property ($rose(o_rx_ready) |->
    o_tx_valid && o_tx_data == osp_pkg::CH_PROMPT) else $error("line opened without prompt");
  AST_CR_CLOSES_LINE: assert property (i_rx_valid && o_rx_ready &&
    i_rx_data == osp_pkg::CH_CR |=> !o_rx_ready) else $error("line still open after CR");
  AST_GATHER_QUIET: assert property (o_rx_ready |-> !o_veh_valid && !o_vrx_ready)
    else $error("vehicle side busy while gathering");
  AST_TX_HOLD: assert property (o_tx_valid && !i_tx_ready |=>
    o_tx_valid && $stable(o_tx_data)) else $error("reply byte dropped");
  AST_VEH_HOLD: assert property (o_veh_valid && !i_veh_ready |=>
    o_veh_valid && $stable(o_veh)) else $error("vehicle byte dropped");
  AST_HEADER_FIRST: assert property ($rose(o_veh_valid) |->
    o_veh.data == HDR[23:16] && !o_veh.last) else $error("request not opened by header");
  AST_LISTEN_AFTER_SEND: assert property (o_veh_valid && i_veh_ready && o_veh.last
    |-> ##[0:3] o_vrx_ready) else $error("not listening after request");
  AST_CAL_PULSE: assert property (o_cal_wr |-> !o_cal_factory ##1 !o_cal_wr)
    else $error("calibrate pulse malformed");
  AST_FACTORY_PULSE: assert property (o_cal_factory |=> !o_cal_factory)
    else $error("factory pulse too long");
  AST_ID_WRITE_ONCE: assert property (wrote_q |-> !o_nvm_id_wr)
    else $error("identifier written twice");
  cover property (o_nvm_id_wr);
  cover property (o_cal_factory);
  cover property (i_vrx_valid && o_vrx_ready && i_vrx.first);
endmodule // osp_parser_checker
bind osp_parser osp_parser_checker #(.HDR(HDR)) i_chk (.i_clk, .i_rst, .i_rx_valid,
  .i_rx_data, .o_rx_ready, .o_tx_valid, .o_tx_data, .i_tx_ready, .o_veh_valid, .o_veh,
  .i_veh_ready, .i_vrx_valid, .i_vrx, .o_vrx_ready, .o_nvm_id_wr, .o_cal_wr, .o_cal_factory);
